// ==== inc/ztp_defines.vh ====
`ifndef ZTP_DEFINES_VH
`define ZTP_DEFINES_VH

// Value width and timing
`define ZTP_VAL_W        24
`define ZTP_CLK_HZ       100000000
`define ZTP_TICK_MS      1
`define ZTP_TICK_CYC     ((`ZTP_CLK_HZ / 1000) * `ZTP_TICK_MS)
`define ZTP_HOLD1_MS     1000
`define ZTP_HOLD2_MS     2000
`define ZTP_PWRUP_MS     3000
`define ZTP_DEB_MS       20

// Lockout levels
`define ZTP_LOCK_OPEN    2'h0
`define ZTP_LOCK_PART    2'h1
`define ZTP_LOCK_CLOSED  2'h2

// Display type settings and main display selection
`define ZTP_DISP_PV      2'h0
`define ZTP_DISP_MAX     2'h1
`define ZTP_DISP_MIN     2'h2

// Register offsets
`define ZTP_REG_CTRL     4'h0
`define ZTP_REG_REF      4'h1
`define ZTP_REG_STAT     4'h2
`define ZTP_REG_DISP     4'h3
`define ZTP_REG_MAX      4'h4
`define ZTP_REG_MIN      4'h5
`define ZTP_REG_OFFS     4'h6
`define ZTP_REG_CMD      4'h7

// Control field positions and reset values
`define ZTP_CTRL_ZLOCK   1:0
`define ZTP_CTRL_MLOCK   3:2
`define ZTP_CTRL_DTYPE   5:4
`define ZTP_CTRL_ZOPT    6
`define ZTP_CTRL_RST     8'h00
`define ZTP_REF_RST      24'h000000

// Command bits
`define ZTP_CMD_PKCLR    0
`define ZTP_CMD_MEAS     1

`endif

// ==== hdl/ztp_debounce.v ====
`timescale 1ns/1ps
`include "ztp_defines.vh"

module ztp_debounce #(
   parameter N      = 3,
   parameter DEB_MS = `ZTP_DEB_MS
) (
   input  wire         ref_clk,
   input  wire         rst,
   input  wire         tick,
   input  wire [N-1:0] raw_in,
   output reg  [N-1:0] clean_out
);

   reg [N-1:0] sync1_reg;
   reg [N-1:0] sync2_reg;
   reg [15:0]  cnt_reg [0:N-1];
   integer     i;

   // Two stages then a level must stay stable for the debounce time
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= {N{1'b0}};
         sync2_reg <= {N{1'b0}};
         clean_out <= {N{1'b0}};
         for (i = 0; i < N; i = i + 1) begin
            cnt_reg[i] <= 16'h0000;
         end
      end else begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
         for (i = 0; i < N; i = i + 1) begin
            if (sync2_reg[i] == clean_out[i]) begin
               cnt_reg[i] <= 16'h0000;
            end else if (tick) begin
               if (cnt_reg[i] >= DEB_MS[15:0]) begin
                  clean_out[i] <= sync2_reg[i];
                  cnt_reg[i]   <= 16'h0000;
               end else begin
                  cnt_reg[i] <= cnt_reg[i] + 16'h0001;
               end
            end
         end
      end
   end

endmodule // ztp_debounce

// ==== hdl/ztp_tracker.v ====
// Overview of operation
// - Up key in measuring mode captures display as zero, enters forced zero.
// - Up key in forced zero captures again and enters tare mode.
// - Up key in tare mode re-captures the zero point again.
// - Zero contact, when option fitted and hold inactive, acts like the up key at open level.
// - Zero lockout: open allows both, partial forced zero only, closed neither.
// - Zero lockout applies to front keys only, never the zero contact.
// - Open level, tare active: one second hold cancels tare to forced zero.
// - Open level: two second hold cancels tare then forced zero.
// - Partial level: one second hold cancels forced zero; keys never enter tare.
// - While max/min shown, zero and tare execute refused, cancel allowed.
// - While reset contact active, zero and tare neither execute nor cancel.
// - Zero and tare still work during input error.
// - Reference value loaded at zero and tare is configurable, default zero.
// - Max/min key steps present value, maximum, minimum, present.
// - Peaks track unless hold or input error active; one second max/min hold clears and restarts.
// - After power-up peak memory held cleared about three seconds.
// - Max/min lockout: open, blocks reset, or blocks stepping and reset.
// - Partial max/min lockout ignores long-hold clear.
// - Reset contact and remote clear never blocked by max/min lockout.
// - Zero and tare actions leave stored peaks unchanged.
// - During input error max and min are not displayed.
// - Display type picks first main display at power-up and measuring return.
// - Hold contact blocks other contacts except reset.
`timescale 1ns/1ps
`include "ztp_defines.vh"

module ztp_tracker #(
   parameter W         = `ZTP_VAL_W,
   parameter TICK_CYC  = `ZTP_TICK_CYC,
   parameter HOLD1_MS  = `ZTP_HOLD1_MS,
   parameter HOLD2_MS  = `ZTP_HOLD2_MS,
   parameter PWRUP_MS  = `ZTP_PWRUP_MS,
   parameter DEB_MS    = `ZTP_DEB_MS
) (
   input  wire         ref_clk,
   input  wire         rst,
   input  wire         up_key,
   input  wire         maxmin_key,
   input  wire         zero_in,
   input  wire         ext_reset_in,
   input  wire         ext_hold_in,
   input  wire         input_error,
   input  wire [W-1:0] meas_val,
   input  wire [3:0]   addr,
   input  wire [W-1:0] wdata,
   input  wire         wr,
   input  wire         rd,
   output reg  [W-1:0] rdata,
   output reg  [W-1:0] disp_val,
   output reg  [1:0]   disp_sel,
   output reg          disp_valid,
   output reg          fz_active,
   output reg          tare_active
);

   localparam ST_MEAS = 3'h1;
   localparam ST_FZ   = 3'h2;
   localparam ST_TARE = 3'h4;

   // Tick counts taken directly from the times in milliseconds
   localparam [31:0] H1 = HOLD1_MS;
   localparam [31:0] H2 = HOLD2_MS;
   localparam [31:0] PU = PWRUP_MS;

   wire [2:0] clean;
   wire       up_c    = clean[0];
   wire       mm_c    = clean[1];
   wire       zero_c  = clean[2];
   reg        rst_s1_reg;
   reg        rst_s2_reg;
   reg        hold_s1_reg;
   reg        hold_s2_reg;
   reg        err_s1_reg;
   reg        err_s2_reg;

   reg [31:0]  tick_cnt_reg;
   reg         tick_reg;
   reg [2:0]   st_reg;
   reg [W-1:0] offs_reg;
   reg [W-1:0] ref_reg;
   reg [7:0]   ctrl_reg;
   reg [W-1:0] max_reg;
   reg [W-1:0] min_reg;
   reg         pk_valid_reg;
   reg [31:0]  pu_cnt_reg;
   reg [31:0]  up_ms_reg;
   reg [31:0]  zr_ms_reg;
   reg [31:0]  mm_ms_reg;
   reg         up_prev_reg;
   reg         zr_prev_reg;
   reg         mm_prev_reg;
   reg         meas_ret_reg;
   reg         pk_clr_cmd_reg;

   wire [1:0] zlock = ctrl_reg[`ZTP_CTRL_ZLOCK];
   wire [1:0] mlock = ctrl_reg[`ZTP_CTRL_MLOCK];
   wire [1:0] dtype = ctrl_reg[`ZTP_CTRL_DTYPE];
   wire       zopt  = ctrl_reg[`ZTP_CTRL_ZOPT];

   ztp_debounce #(
      .N      (3),
      .DEB_MS (DEB_MS)
   ) u_deb (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .tick      (tick_reg),
      .raw_in    ({zero_in, maxmin_key, up_key}),
      .clean_out (clean)
   );

   // Level contacts only need synchronising
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rst_s1_reg  <= 1'b0;
         rst_s2_reg  <= 1'b0;
         hold_s1_reg <= 1'b0;
         hold_s2_reg <= 1'b0;
         err_s1_reg  <= 1'b0;
         err_s2_reg  <= 1'b0;
      end else begin
         rst_s1_reg  <= ext_reset_in;
         rst_s2_reg  <= rst_s1_reg;
         hold_s1_reg <= ext_hold_in;
         hold_s2_reg <= hold_s1_reg;
         err_s1_reg  <= input_error;
         err_s2_reg  <= err_s1_reg;
      end
   end

   // Millisecond tick
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tick_cnt_reg <= 32'h00000000;
         tick_reg     <= 1'b0;
      end else if (tick_cnt_reg >= TICK_CYC - 1) begin
         tick_cnt_reg <= 32'h00000000;
         tick_reg     <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
         tick_reg     <= 1'b0;
      end
   end

   // Hold blocks the zero contact; only with option fitted
   wire zr_en = zero_c & zopt & ~hold_s2_reg;

   wire up_rel  = up_prev_reg & ~up_c;
   wire zr_rel  = zr_prev_reg & ~zr_en;
   wire mm_rel  = mm_prev_reg & ~mm_c;
   wire up_short = up_rel & (up_ms_reg < H1);
   wire zr_short = zr_rel & (zr_ms_reg < H1);
   wire mm_short = mm_rel & (mm_ms_reg < H1);
   wire up_at1  = up_c & tick_reg & (up_ms_reg == H1 - 1);
   wire up_at2  = up_c & tick_reg & (up_ms_reg == H2 - 1);
   wire zr_at1  = zr_en & tick_reg & (zr_ms_reg == H1 - 1);
   wire zr_at2  = zr_en & tick_reg & (zr_ms_reg == H2 - 1);
   wire mm_at1  = mm_c & tick_reg & (mm_ms_reg == H1 - 1);

   // No execute or cancel while the reset contact is active
   wire zallow = ~rst_s2_reg;
   // Execute refused while a peak is shown
   wire showing_pk = (disp_sel != `ZTP_DISP_PV);
   wire key_fz_ok   = (zlock != `ZTP_LOCK_CLOSED);
   wire key_tare_ok = (zlock == `ZTP_LOCK_OPEN);
   // Partial level: hold cancels forced zero outright at one second
   wire key_cnl1 = up_at1 & key_fz_ok;
   wire key_cnl2 = up_at2 & key_tare_ok;

   wire exec_req = zallow & ~showing_pk &
                   ((up_short & key_fz_ok & (st_reg == ST_MEAS | key_tare_ok)) | zr_short);
   wire cnl1_req = zallow & (key_cnl1 | zr_at1);
   wire cnl2_req = zallow & (key_cnl2 | zr_at2);

   wire [W-1:0] rel_val = meas_val - offs_reg;

   // Zero state machine
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_reg   <= ST_MEAS;
         offs_reg <= {W{1'b0}};
      end else begin
         case (st_reg)
            ST_MEAS: begin
               if (exec_req) begin
                  offs_reg <= meas_val;
                  st_reg   <= ST_FZ;
               end
            end
            ST_FZ: begin
               if (exec_req) begin
                  offs_reg <= meas_val;
                  st_reg   <= ST_TARE;
               end else if (zallow & up_at1 & (zlock == `ZTP_LOCK_PART)) begin
                  offs_reg <= {W{1'b0}};
                  st_reg   <= ST_MEAS;
               end else if (cnl2_req) begin
                  offs_reg <= {W{1'b0}};
                  st_reg   <= ST_MEAS;
               end
            end
            ST_TARE: begin
               if (exec_req) begin
                  offs_reg <= meas_val;
               end else if (cnl1_req) begin
                  offs_reg <= meas_val;
                  st_reg   <= ST_FZ;
               end
            end
            default: begin
               st_reg <= ST_MEAS;
            end
         endcase
      end
   end

   // Hold timers and edge history
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         up_ms_reg   <= 32'h00000000;
         zr_ms_reg   <= 32'h00000000;
         mm_ms_reg   <= 32'h00000000;
         up_prev_reg <= 1'b0;
         zr_prev_reg <= 1'b0;
         mm_prev_reg <= 1'b0;
      end else begin
         up_prev_reg <= up_c;
         zr_prev_reg <= zr_en;
         mm_prev_reg <= mm_c;
         if (!up_c && !up_rel) up_ms_reg <= 32'h00000000;
         else if (up_c && tick_reg) up_ms_reg <= up_ms_reg + 32'h00000001;
         if (!zr_en && !zr_rel) zr_ms_reg <= 32'h00000000;
         else if (zr_en && tick_reg) zr_ms_reg <= zr_ms_reg + 32'h00000001;
         if (!mm_c && !mm_rel) mm_ms_reg <= 32'h00000000;
         else if (mm_c && tick_reg) mm_ms_reg <= mm_ms_reg + 32'h00000001;
      end
   end

   // Peak tracking
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pu_cnt_reg   <= 32'h00000000;
         pk_valid_reg <= 1'b0;
         max_reg      <= {W{1'b0}};
         min_reg      <= {W{1'b0}};
      end else if (pu_cnt_reg < PU) begin
         if (tick_reg) pu_cnt_reg <= pu_cnt_reg + 32'h00000001;
         pk_valid_reg <= 1'b0;
         max_reg      <= {W{1'b0}};
         min_reg      <= {W{1'b0}};
      end else if (rst_s2_reg | pk_clr_cmd_reg | (mm_at1 & (mlock == `ZTP_LOCK_OPEN))) begin
         // Contact and remote clear bypass lockout; key clear
         pk_valid_reg <= 1'b0;
      end else if (~hold_s2_reg & ~err_s2_reg) begin
         // Track displayed value; zero actions do not touch peaks
         pk_valid_reg <= 1'b1;
         if (!pk_valid_reg || $signed(rel_val + ref_reg) > $signed(max_reg)) max_reg <= rel_val + ref_reg;
         if (!pk_valid_reg || $signed(rel_val + ref_reg) < $signed(min_reg)) min_reg <= rel_val + ref_reg;
      end
   end

   // Display selection and outputs
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         disp_sel    <= `ZTP_DISP_PV;
         disp_val    <= {W{1'b0}};
         disp_valid  <= 1'b0;
         fz_active   <= 1'b0;
         tare_active <= 1'b0;
      end else begin
         if (meas_ret_reg) begin
            disp_sel <= (dtype == 2'h3) ? `ZTP_DISP_PV : dtype;
         end else if (mm_short & (mlock != `ZTP_LOCK_CLOSED) & ~err_s2_reg) begin
            // Step display; closed level and error block it
            case (disp_sel)
               `ZTP_DISP_PV:  disp_sel <= `ZTP_DISP_MAX;
               `ZTP_DISP_MAX: disp_sel <= `ZTP_DISP_MIN;
               default:       disp_sel <= `ZTP_DISP_PV;
            endcase
         end
         // Display value with offset and reference; no peaks on error
         if (disp_sel == `ZTP_DISP_MAX && !err_s2_reg) disp_val <= max_reg;
         else if (disp_sel == `ZTP_DISP_MIN && !err_s2_reg) disp_val <= min_reg;
         else disp_val <= rel_val + ref_reg;
         disp_valid  <= ~rst_s2_reg & (disp_sel == `ZTP_DISP_PV | (~err_s2_reg & pk_valid_reg));
         // Error state does not gate zero actions
         fz_active   <= (st_reg != ST_MEAS);
         tare_active <= (st_reg == ST_TARE);
      end
   end

   // Register port, read data one cycle later
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg       <= `ZTP_CTRL_RST;
         ref_reg        <= `ZTP_REF_RST;
         rdata          <= {W{1'b0}};
         meas_ret_reg   <= 1'b1;
         pk_clr_cmd_reg <= 1'b0;
      end else begin
         meas_ret_reg   <= 1'b0;
         pk_clr_cmd_reg <= 1'b0;
         if (wr) begin
            case (addr)
               `ZTP_REG_CTRL: ctrl_reg <= wdata[7:0];
               `ZTP_REG_REF:  ref_reg  <= wdata;
               `ZTP_REG_CMD: begin
                  pk_clr_cmd_reg <= wdata[`ZTP_CMD_PKCLR];
                  meas_ret_reg   <= wdata[`ZTP_CMD_MEAS];
               end
               default: ;
            endcase
         end
         if (rd) begin
            case (addr)
               `ZTP_REG_CTRL: rdata <= {{(W-8){1'b0}}, ctrl_reg};
               `ZTP_REG_REF:  rdata <= ref_reg;
               `ZTP_REG_STAT: rdata <= {{(W-8){1'b0}}, pk_valid_reg, rst_s2_reg, hold_s2_reg,
                                        err_s2_reg, disp_sel, tare_active, fz_active};
               `ZTP_REG_DISP: rdata <= disp_val;
               `ZTP_REG_MAX:  rdata <= max_reg;
               `ZTP_REG_MIN:  rdata <= min_reg;
               `ZTP_REG_OFFS: rdata <= offs_reg;
               default:       rdata <= {W{1'b0}};
            endcase
         end else begin
            rdata <= {W{1'b0}};
         end
      end
   end

endmodule // ztp_tracker

// ==== tb/ztp_tracker_chk.sv ====
`timescale 1ns/1ps
module ztp_tracker_chk #(
   parameter W = 24
) (
   input wire         ref_clk,
   input wire         rst,
   input wire         rd,
   input wire [3:0]   addr,
   input wire [W-1:0] rdata,
   input wire         ext_reset_in,
   input wire         input_error,
   input wire [1:0]   disp_sel,
   input wire         fz_active,
   input wire         tare_active
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Six raw cycles outlast the two-stage synchroniser
   sequence reset_held; ext_reset_in [*6]; endsequence
   sequence error_held; input_error [*6]; endsequence
   rdata_idle_a: assert property (!$past(rd) |-> rdata == '0)
      else $error("read data not zero outside a read");
   unmapped_rd_a: assert property (rd && addr[3] |=> rdata == '0)
      else $error("unmapped read not zero");
   tare_fz_a: assert property (tare_active |-> fz_active)
      else $error("tare without forced zero");
   tare_entry_a: assert property ($rose(tare_active) |-> $past(fz_active))
      else $error("tare entered from measuring");
   exec_present_a: assert property ($rose(fz_active) |-> $past(disp_sel) == 2'h0)
      else $error("zero executed during peak display");
   reset_freeze_a: assert property (reset_held |=> $stable({fz_active, tare_active}))
      else $error("zero state moved under reset contact");
   error_step_a: assert property (error_held |-> !(disp_sel != 2'h0 && $past(disp_sel) == 2'h0))
      else $error("peak shown during input error");
   step_order_a: assert property ($changed(disp_sel) && disp_sel == 2'h2 |-> $past(disp_sel) == 2'h1)
      else $error("minimum not reached from maximum");
   sel_legal_a: assert property (disp_sel != 2'h3)
      else $error("illegal display selection");
endmodule // ztp_tracker_chk

bind ztp_tracker ztp_tracker_chk #(.W(W)) u_chk (.ref_clk(ref_clk), .rst(rst), .rd(rd), .addr(addr),
   .rdata(rdata), .ext_reset_in(ext_reset_in), .input_error(input_error), .disp_sel(disp_sel),
   .fz_active(fz_active), .tare_active(tare_active));

// ==== tb/ztp_operator.sv ====
`timescale 1ns/1ps
module ztp_operator (
   input  wire  ref_clk,
   output logic up_key,
   output logic maxmin_key,
   output logic zero_in
);
   initial begin
      up_key = 1'b0;
      maxmin_key = 1'b0;
      zero_in = 1'b0;
   end
   // short press or timed hold
   // Contacts rest open, so a released key reads low
   task automatic press(input logic [1:0] key, input int cyc);
      @(posedge ref_clk);
      up_key <= (key == 2'h0);
      maxmin_key <= (key == 2'h1);
      zero_in <= (key == 2'h2);
      repeat (cyc) @(posedge ref_clk);
      up_key <= 1'b0;
      maxmin_key <= 1'b0;
      zero_in <= 1'b0;
      // Room for debounce and the action after release
      repeat (40) @(posedge ref_clk);
   endtask
endmodule // ztp_operator

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`include "ztp_defines.vh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fail_count++; $display("mismatch %s exp %0h got %0h", n, e, a); end end
module tb;
   localparam W = `ZTP_VAL_W;
   localparam S = 30;
   localparam L = 100;
   localparam LL = 200;
   logic         ref_clk = 1'b0;
   logic         rst = 1'b1;
   logic         up_key, maxmin_key, zero_in;
   logic         ext_reset_in = 1'b0, ext_hold_in = 1'b0, input_error = 1'b0;
   logic [W-1:0] meas_val = 24'h000064;
   logic [3:0]   addr = 4'h0;
   logic [W-1:0] wdata = 24'h000000;
   logic         wr_s = 1'b0, rd_s = 1'b0;
   logic [W-1:0] rdata, disp_val, rv;
   logic [1:0]   disp_sel;
   logic         disp_valid, fz_active, tare_active;
   logic [28:0]  rows [0:7];
   int           fail_count = 0, compares = 0, cyc = 0;

   always #5 ref_clk = ~ref_clk;

   ztp_operator OP (.ref_clk(ref_clk), .up_key(up_key), .maxmin_key(maxmin_key), .zero_in(zero_in));

   // Short counts keep the run brief; holds sit well apart
   ztp_tracker #(.TICK_CYC(10), .HOLD1_MS(6), .HOLD2_MS(14), .PWRUP_MS(5), .DEB_MS(1)) DUT (
      .ref_clk(ref_clk), .rst(rst), .up_key(up_key), .maxmin_key(maxmin_key), .zero_in(zero_in),
      .ext_reset_in(ext_reset_in), .ext_hold_in(ext_hold_in), .input_error(input_error),
      .meas_val(meas_val), .addr(addr), .wdata(wdata), .wr(wr_s), .rd(rd_s), .rdata(rdata),
      .disp_val(disp_val), .disp_sel(disp_sel), .disp_valid(disp_valid), .fz_active(fz_active),
      .tare_active(tare_active));

   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         finish_test;
      end
   end

   task automatic reg_wr(input logic [3:0] a, input logic [W-1:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge ref_clk);
      wr_s <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a);
      @(posedge ref_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge ref_clk);
      rd_s <= 1'b0;
      #1 rv = rdata;
   endtask

   task automatic st(input logic f, input logic t);
      `CHK("fz", f, fz_active)
      `CHK("tare", t, tare_active)
   endtask

   task automatic meas(input logic [W-1:0] v);
      meas_val <= v;
      repeat (10) @(posedge ref_clk);
   endtask

   initial begin
      rows[0] = {1'b0, `ZTP_REG_CTRL, 24'h000000};
      rows[1] = {1'b0, `ZTP_REG_REF, `ZTP_REF_RST};
      rows[2] = {1'b0, `ZTP_REG_STAT, 24'h000000};
      rows[3] = {1'b0, 4'h8, 24'h000000};
      rows[4] = {1'b1, 4'h9, 24'hFFFFFF};
      rows[5] = {1'b0, 4'h9, 24'h000000};
      rows[6] = {1'b1, `ZTP_REG_REF, 24'h000005};
      rows[7] = {1'b0, `ZTP_REG_REF, 24'h000005};
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (rows[i][28]) begin
            reg_wr(rows[i][27:24], rows[i][23:0]);
         end else begin
            reg_rd(rows[i][27:24]);
            `CHK("reg", rows[i][23:0], rv)
         end
      end
      $display("test registers done");
      repeat (60) @(posedge ref_clk);
      reg_rd(`ZTP_REG_STAT);
      `CHK("pk_valid", 1'b1, rv[7])
      OP.press(2'h0, S); st(1'b1, 1'b0);
      `CHK("disp", 24'h000005, disp_val)
      meas(24'h000082); `CHK("disp", 24'h000023, disp_val)
      OP.press(2'h0, S); st(1'b1, 1'b1);
      meas(24'h000096); OP.press(2'h0, S); st(1'b1, 1'b1);
      `CHK("disp", 24'h000005, disp_val)
      OP.press(2'h0, L); st(1'b1, 1'b0);
      reg_wr(`ZTP_REG_REF, 24'h000000);
      OP.press(2'h0, S); OP.press(2'h0, LL); st(1'b0, 1'b0);
      `CHK("disp", 24'h000096, disp_val)
      $display("test open level done");
      reg_wr(`ZTP_REG_CTRL, 24'h000001);
      OP.press(2'h0, S); OP.press(2'h0, S); st(1'b1, 1'b0);
      OP.press(2'h0, L); st(1'b0, 1'b0);
      reg_wr(`ZTP_REG_CTRL, 24'h000002);
      OP.press(2'h0, S); st(1'b0, 1'b0);
      reg_wr(`ZTP_REG_CTRL, 24'h000042);
      OP.press(2'h2, S); st(1'b1, 1'b0);
      OP.press(2'h2, L); st(1'b1, 1'b0);
      OP.press(2'h2, LL); st(1'b0, 1'b0);
      ext_hold_in <= 1'b1;
      OP.press(2'h2, S); st(1'b0, 1'b0);
      ext_hold_in <= 1'b0;
      reg_wr(`ZTP_REG_CTRL, 24'h000000);
      ext_reset_in <= 1'b1;
      OP.press(2'h0, S); st(1'b0, 1'b0);
      `CHK("valid", 1'b0, disp_valid)
      ext_reset_in <= 1'b0;
      input_error <= 1'b1;
      OP.press(2'h1, S); `CHK("sel", 2'h0, disp_sel)
      OP.press(2'h0, S); st(1'b1, 1'b0);
      OP.press(2'h0, LL); st(1'b0, 1'b0);
      input_error <= 1'b0;
      $display("test lockout and contacts done");
      meas(24'h0000C8); meas(24'h000078); meas(24'h000096);
      reg_rd(`ZTP_REG_MAX); `CHK("max", 24'h0000C8, rv)
      reg_rd(`ZTP_REG_MIN); `CHK("min", 24'h000078, rv)
      reg_wr(`ZTP_REG_CTRL, 24'h000004);
      OP.press(2'h1, L); reg_rd(`ZTP_REG_MAX); `CHK("max", 24'h0000C8, rv)
      reg_wr(`ZTP_REG_CTRL, 24'h000000);
      OP.press(2'h1, L); reg_rd(`ZTP_REG_MAX); `CHK("max", 24'h000096, rv)
      meas(24'h0000C8); reg_wr(`ZTP_REG_CTRL, 24'h000008);
      reg_wr(`ZTP_REG_CMD, 24'h000001); meas(24'h0000C8);
      reg_rd(`ZTP_REG_MIN); `CHK("min", 24'h0000C8, rv)
      OP.press(2'h1, S); `CHK("sel", 2'h0, disp_sel)
      reg_wr(`ZTP_REG_CTRL, 24'h000000);
      for (int i = 1; i < 4; i++) begin
         OP.press(2'h1, S); `CHK("sel", 2'(i % 3), disp_sel)
      end
      reg_wr(`ZTP_REG_CTRL, 24'h000010); reg_wr(`ZTP_REG_CMD, 24'h000002); meas(24'h0000C8);
      `CHK("sel", 2'h1, disp_sel)
      `CHK("disp", 24'h0000C8, disp_val)
      `CHK("valid", 1'b1, disp_valid)
      OP.press(2'h0, S); st(1'b0, 1'b0);
      reg_wr(`ZTP_REG_CTRL, 24'h000000); reg_wr(`ZTP_REG_CMD, 24'h000002);
      OP.press(2'h0, S); st(1'b1, 1'b0);
      reg_rd(`ZTP_REG_MAX); `CHK("max", 24'h0000C8, rv)
      $display("test peaks and display done");
      finish_test;
   end
endmodule // tb
